// file: verilog/pmfh_pkg.sv
// pmfh_pkg: constants and carriers for the converter telemetry and fault handler.
// assumes a single 50 MHz clock domain and a synchronous active-high reset.
package pmfh_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned VOUT_W          = 12;
  localparam int unsigned IOUT_W          = 8;
  localparam int unsigned TEMP_W          = 8;
  localparam int unsigned REFRESH_MS      = 1000;
  localparam int unsigned HICCUP_MS       = 130;
  localparam int unsigned MIN_HOST_TO_MS  = 150;
  localparam int unsigned REFRESH_CYC     = (CLK_HZ / 1000) * REFRESH_MS;
  localparam int unsigned HICCUP_CYC      = (CLK_HZ / 1000) * HICCUP_MS;
  localparam int unsigned NUM_GROUPS      = 3;
  localparam int unsigned NUM_FAULTS      = 4;
  localparam logic [7:0]  TEMP_REF        = 8'h19;
  localparam logic [7:0]  COMP_SHIFT      = 8'h08;
  localparam int unsigned CNT_W           = 27;

  typedef struct packed {
    logic [VOUT_W-1:0] vout_reading;
    logic [IOUT_W-1:0] iout_reading;
    logic [TEMP_W-1:0] temp_reading;
  } pmfh_telem_t;

  typedef struct packed {
    logic [NUM_FAULTS-1:0] inject_set;
    logic [NUM_FAULTS-1:0] inject_clr;
    logic [NUM_FAULTS-1:0] latching;
    logic                  cmd_off;
    logic                  cmd_on;
  } pmfh_fctl_t;

  typedef enum logic [1:0] {
    PMFH_OFF,
    PMFH_RUN,
    PMFH_FAULT,
    PMFH_HICCUP
  } pmfh_state_t;
endpackage : pmfh_pkg

// file: verilog/pmfh_top.sv
// pmfh_top: converter telemetry, manager polling and fault recovery in one block.
// assumes pins are asynchronous and pass two flops; all control bits are plain ports.
`timescale 1ns/1ps
// Behaviour
// - voltage is a 12-bit reading; current and temperature are 8-bit readings.
// - current reading is corrected from temperature for inductor resistance drift.
// - manager copies of readings refresh every one second.
// - converter-bus service has priority over host I2C answers.
// - overlapping host transaction is held until converter-bus activity ends.
// - auto-on group turns on once bus power present and members configured.
// - parametric polling per group; converter measures regardless.
// - low power-good always seen; status polled only when enabled.
// - held fault trigger acts exactly like a real fault of that type.
// - fault shuts own group if configured, other groups if own-group and inter-group propagation both enabled.
// - non-latching fault restarts after 130 ms hiccup once cleared.
// - latching fault stays off and latched when trigger removed.
// - enable toggle or off-then-on command clears latch; the command re-enables, the toggle only with auto-on.
module pmfh_top
  import pmfh_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = REFRESH_CYC,
  parameter int unsigned HICCUP_CYCLES  = HICCUP_CYC
) (
  input  wire logic                  clk_in,
  input  wire logic                  srst_in,
  input  wire logic [VOUT_W-1:0]     adc_vout_in,
  input  wire logic [IOUT_W-1:0]     adc_iout_in,
  input  wire logic [TEMP_W-1:0]     adc_temp_in,
  input  wire logic [NUM_FAULTS-1:0] real_fault_in,
  input  wire pmfh_fctl_t            fault_ctl_in,
  input  wire logic                  enable_pin_in,
  input  wire logic                  ibus_power_in,
  input  wire logic                  configured_in,
  input  wire logic                  auto_on_in,
  input  wire logic                  p_monitor_in,
  input  wire logic                  s_monitor_in,
  input  wire logic                  group_prop_in,
  input  wire logic [NUM_GROUPS-1:0] inter_group_prop_in,
  input  wire logic                  power_good_in,
  input  wire logic                  sync_comm_busy_in,
  input  wire logic                  host_req_in,
  output logic                       host_hold_out,
  output logic                       host_grant_out,
  output pmfh_telem_t                conv_telem_out,
  output pmfh_telem_t                mgr_telem_out,
  output logic                       poll_strobe_out,
  output logic                       status_poll_out,
  output logic                       pg_low_out,
  output logic                       output_on_out,
  output logic [NUM_FAULTS-1:0]      active_fault_out,
  output logic [NUM_FAULTS-1:0]      latched_fault_out,
  output logic                       group_shutdown_out,
  output logic [NUM_GROUPS-1:0]      other_group_shutdown_out,
  output pmfh_state_t                state_out
);
  // elaboration guard: both counters are CNT_W bits and need at least two states
  if (REFRESH_CYCLES < 2 || HICCUP_CYCLES < 2 || REFRESH_CYCLES >= (1 << CNT_W)
      || HICCUP_CYCLES >= (1 << CNT_W)) begin : g_bad_counts
    $error("pmfh_top: cycle counts out of range");
  end

  // two-flop synchronisers for every pin input
  // adc words are not gray coded; a sample that straddles an edge is fixed by the next one
  pmfh_telem_t           adc_s1, adc_s2;
  logic [NUM_FAULTS-1:0] flt_s1, flt_s2;
  logic [4:0]            pin_s1, pin_s2;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      adc_s1 <= '0;
      adc_s2 <= '0;
      flt_s1 <= '0;
      flt_s2 <= '0;
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
    end else begin
      adc_s1 <= {adc_vout_in, adc_iout_in, adc_temp_in};
      adc_s2 <= adc_s1;
      flt_s1 <= real_fault_in;
      flt_s2 <= flt_s1;
      pin_s1 <= {enable_pin_in, ibus_power_in, power_good_in, sync_comm_busy_in, host_req_in};
      pin_s2 <= pin_s1;
    end
  end
  logic en_pin, ib_pwr, pg, sc_busy, h_req;
  assign {en_pin, ib_pwr, pg, sc_busy, h_req} = pin_s2;

  // registered state
  pmfh_telem_t           conv, mgr;
  logic [CNT_W-1:0]      ref_cnt, hic_cnt;
  logic [NUM_FAULTS-1:0] inject, latched;
  logic                  en_d, off_seen, poll, spoll;
  pmfh_state_t           state;
  pmfh_telem_t           next_conv, next_mgr;
  logic [CNT_W-1:0]      next_ref_cnt, next_hic_cnt;
  logic [NUM_FAULTS-1:0] next_inject, next_latched;
  logic                  next_en_d, next_off_seen, next_poll, next_spoll;
  pmfh_state_t           next_state;

  logic [NUM_FAULTS-1:0] fault_now;
  logic                  any_latched, en_toggle, refresh_due;
  logic signed [9:0]     temp_delta;
  logic signed [17:0]    comp_prod;
  logic [IOUT_W+1:0]     iout_sum;

  // current compensation: about 1/256 per degree away from reference, saturated
  // arithmetic shift floors a negative correction, so cold readings round up by one lsb
  always_comb begin
    temp_delta = 10'(signed'({2'b00, adc_s2.temp_reading})) - 10'(signed'({2'b00, TEMP_REF}));
    comp_prod  = 18'(signed'({8'h00, adc_s2.iout_reading}) * temp_delta);
    iout_sum   = 10'({2'b00, adc_s2.iout_reading}) - 10'(comp_prod >>> COMP_SHIFT);
  end

  always_comb begin
    fault_now   = inject | flt_s2;
    any_latched = |latched;
    en_toggle   = en_d & ~en_pin;
    refresh_due = (ref_cnt == CNT_W'(REFRESH_CYCLES - 1));
  end

  // next-state logic for telemetry, polling and fault handling
  always_comb begin
    next_conv     = conv;
    next_mgr      = mgr;
    next_ref_cnt  = refresh_due ? '0 : ref_cnt + 1'b1;
    next_hic_cnt  = hic_cnt;
    next_inject   = (inject & ~fault_ctl_in.inject_clr) | fault_ctl_in.inject_set;
    next_latched  = latched | (fault_now & fault_ctl_in.latching);
    next_en_d     = en_pin;
    next_off_seen = off_seen;
    next_poll     = 1'b0;
    next_spoll    = 1'b0;
    next_state    = state;
    // converter always measures, even with polling off
    next_conv.vout_reading = adc_s2.vout_reading;
    next_conv.temp_reading = adc_s2.temp_reading;
    next_conv.iout_reading = iout_sum[IOUT_W+1] ? '0 :
                             (iout_sum[IOUT_W] ? '1 : iout_sum[IOUT_W-1:0]);
    // periodic polls share one free counter, so both kinds of query stay aligned
    if (refresh_due) begin
      next_poll  = p_monitor_in;
      next_spoll = s_monitor_in;
      if (p_monitor_in) begin
        next_mgr = conv;
      end
    end
    // off command (or enable fall) arms and clears the latch; on command then restarts
    // auto-on restarts an off group at once, so a held-off group needs auto-on low
    if (fault_ctl_in.cmd_off || en_toggle) begin
      next_off_seen = 1'b1;
      next_latched  = fault_now & fault_ctl_in.latching;
      next_state    = PMFH_OFF;
    end
    unique case (state)
      PMFH_OFF: begin
        if (fault_ctl_in.cmd_off) begin
          next_state = PMFH_OFF;
        end else if ((fault_ctl_in.cmd_on && off_seen) || (en_pin && auto_on_in
                     && ib_pwr && configured_in)) begin
          next_off_seen = 1'b0;
          next_state    = (|fault_now || any_latched) ? PMFH_FAULT : PMFH_RUN;
        end
      end
      PMFH_RUN: begin
        if (|fault_now) begin
          next_state = PMFH_FAULT;
        end
      end
      PMFH_FAULT: begin
        // latched faults hold the converter off after the trigger goes
        if (!(|fault_now) && !any_latched) begin
          next_state   = PMFH_HICCUP;
          next_hic_cnt = '0;
        end
      end
      PMFH_HICCUP: begin
        // a fault during the wait sends the converter back to the fault state
        next_hic_cnt = hic_cnt + 1'b1;
        if (|fault_now) begin
          next_state = PMFH_FAULT;
        end else if (hic_cnt == CNT_W'(HICCUP_CYCLES - 1)) begin
          next_state = PMFH_RUN;
        end
      end
    endcase
    // off command wins over every transition above; enable fall wins over all but an on command in the off state
    if ((fault_ctl_in.cmd_off || en_toggle) && state != PMFH_OFF) begin
      next_state = PMFH_OFF;
    end
  end

  // synchronous reset only; all state lives in the one clock domain
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      conv     <= '0;
      mgr      <= '0;
      ref_cnt  <= '0;
      hic_cnt  <= '0;
      inject   <= '0;
      latched  <= '0;
      en_d     <= 1'b0;
      off_seen <= 1'b0;
      poll     <= 1'b0;
      spoll    <= 1'b0;
      state    <= PMFH_OFF;
    end else begin
      conv     <= next_conv;
      mgr      <= next_mgr;
      ref_cnt  <= next_ref_cnt;
      hic_cnt  <= next_hic_cnt;
      inject   <= next_inject;
      latched  <= next_latched;
      en_d     <= next_en_d;
      off_seen <= next_off_seen;
      poll     <= next_poll;
      spoll    <= next_spoll;
      state    <= next_state;
    end
  end

  // outputs; host is held whenever the sync line is active
  // grant is a level; the host must see it drop before asking again
  logic in_fault;
  assign in_fault                 = (state == PMFH_FAULT) || (state == PMFH_HICCUP);
  assign host_hold_out            = h_req & sc_busy;
  assign host_grant_out           = h_req & ~sc_busy;
  assign conv_telem_out           = conv;
  assign mgr_telem_out            = mgr;
  assign poll_strobe_out          = poll;
  assign status_poll_out          = spoll;
  assign pg_low_out               = ~pg;
  assign output_on_out            = (state == PMFH_RUN);
  assign active_fault_out         = inject;
  assign latched_fault_out        = latched;
  assign group_shutdown_out       = in_fault & group_prop_in;
  // per-group mask; other groups follow only behind own-group propagation
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_other_grp
    assign other_group_shutdown_out[g] = in_fault & group_prop_in
                                         & inter_group_prop_in[g];
  end
  assign state_out                = state;

  // checks
  chk_fault_stops: assert property (@(posedge clk_in) disable iff (srst_in)
    (state == PMFH_RUN && |fault_now && !fault_ctl_in.cmd_off && !en_toggle)
      |=> state == PMFH_FAULT) else $error("fault did not stop output");
  chk_hiccup_len: assert property (@(posedge clk_in) disable iff (srst_in)
    (state == PMFH_HICCUP && hic_cnt == CNT_W'(HICCUP_CYCLES - 1) && !(|fault_now)
      && !fault_ctl_in.cmd_off && !en_toggle) |=> state == PMFH_RUN)
    else $error("hiccup restart missed");
  chk_latch_holds: assert property (@(posedge clk_in) disable iff (srst_in)
    (state == PMFH_FAULT && any_latched) |=> state != PMFH_HICCUP && state != PMFH_RUN)
    else $error("latched fault restarted");
  chk_off_clears: assert property (@(posedge clk_in) disable iff (srst_in)
    (fault_ctl_in.cmd_off && !(|fault_now)) |=> latched == '0 && state == PMFH_OFF)
    else $error("off command left latch");
  chk_inject_level: assert property (@(posedge clk_in) disable iff (srst_in)
    (|fault_ctl_in.inject_set) |=> ((inject & $past(fault_ctl_in.inject_set)) != '0))
    else $error("inject not held");
  chk_hold_busy: assert property (@(posedge clk_in) disable iff (srst_in)
    sc_busy |-> !host_grant_out) else $error("host served during bus activity");
  chk_refresh_copy: assert property (@(posedge clk_in) disable iff (srst_in)
    (refresh_due && p_monitor_in) |=> poll && mgr == $past(conv))
    else $error("refresh missed");
  chk_prop_scope: assert property (@(posedge clk_in) disable iff (srst_in)
    ((other_group_shutdown_out & ~inter_group_prop_in) == '0) && (group_shutdown_out
      == (in_fault & group_prop_in))) else $error("propagation out of scope");
  chk_status_gate: assert property (@(posedge clk_in) disable iff (srst_in)
    status_poll_out |-> $past(s_monitor_in)) else $error("status poll when off");

  // start-up, telemetry and recovery checks; each antecedent is reached by the bench
  chk_auto_start: assert property (@(posedge clk_in) disable iff (srst_in)
    (state == PMFH_OFF && en_pin && auto_on_in && ib_pwr && configured_in
      && !fault_ctl_in.cmd_off && !(|fault_now) && !any_latched) |=> state == PMFH_RUN)
    else $error("auto start missed");
  chk_conv_live: assert property (@(posedge clk_in) disable iff (srst_in)
    conv.vout_reading == $past(adc_s2.vout_reading))
    else $error("voltage reading stalled");
  chk_temp_live: assert property (@(posedge clk_in) disable iff (srst_in)
    conv.temp_reading == $past(adc_s2.temp_reading))
    else $error("temperature reading stalled");
  chk_comp_flat: assert property (@(posedge clk_in) disable iff (srst_in)
    (adc_s2.temp_reading == TEMP_REF) |=> conv.iout_reading == $past(adc_s2.iout_reading))
    else $error("current changed at reference temperature");
  chk_poll_gate: assert property (@(posedge clk_in) disable iff (srst_in)
    poll_strobe_out |-> $past(p_monitor_in)) else $error("poll while disabled");
  chk_mgr_hold: assert property (@(posedge clk_in) disable iff (srst_in)
    !p_monitor_in |=> mgr == $past(mgr)) else $error("copy changed without polling");
  chk_spoll_pulse: assert property (@(posedge clk_in) disable iff (srst_in)
    status_poll_out |=> !status_poll_out) else $error("status poll longer than a cycle");
  chk_latch_set: assert property (@(posedge clk_in) disable iff (srst_in)
    (|(fault_now & fault_ctl_in.latching) && !fault_ctl_in.cmd_off && !en_toggle)
      |=> any_latched) else $error("latching fault not latched");
  chk_lone_on: assert property (@(posedge clk_in) disable iff (srst_in)
    (state == PMFH_FAULT && any_latched && fault_ctl_in.cmd_on && !fault_ctl_in.cmd_off
      && !en_toggle) |=> state == PMFH_FAULT && any_latched)
    else $error("lone on cleared latch");
  chk_toggle_off: assert property (@(posedge clk_in) disable iff (srst_in)
    (en_toggle && !fault_ctl_in.cmd_on && !(|fault_now))
      |=> state == PMFH_OFF && latched == '0) else $error("enable toggle left output on");
  chk_inject_clear: assert property (@(posedge clk_in) disable iff (srst_in)
    (|fault_ctl_in.inject_clr && !(|fault_ctl_in.inject_set))
      |=> (inject & $past(fault_ctl_in.inject_clr)) == '0) else $error("trigger not cleared");
endmodule : pmfh_top

// file: sim/pmfh_far_model.sv
// pmfh_far_model: manager-side sync bus bursts plus one host I2C request.
// assumes the block's clock; a go_in pulse starts a burst and a request together.
`timescale 1ns/1ps
module pmfh_far_model
  import pmfh_pkg::*;
#(
  parameter int unsigned HOST_TO_CYC = 400
) (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       go_in,
  input  wire logic [7:0] busy_len_in,
  input  wire logic       grant_in,
  output logic            sync_comm_busy_out,
  output logic            host_req_out,
  output logic            timed_out_out
);
  int busy_cnt;
  int wait_cnt;
  // burst length may be short or long; the host drops its request on grant, or at the HOST_TO_CYC limit
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      busy_cnt           <= 0;
      wait_cnt           <= 0;
      sync_comm_busy_out <= 1'b0;
      host_req_out       <= 1'b0;
      timed_out_out      <= 1'b0;
    end else if (go_in) begin
      busy_cnt           <= int'(busy_len_in);
      wait_cnt           <= 0;
      sync_comm_busy_out <= 1'b1;
      host_req_out       <= 1'b1;
    end else begin
      busy_cnt           <= (busy_cnt > 1) ? busy_cnt - 1 : 0;
      sync_comm_busy_out <= busy_cnt > 1;
      if (host_req_out && grant_in) host_req_out <= 1'b0;
      else if (host_req_out) wait_cnt <= wait_cnt + 1;
      // limit sized above any full poll, so a held bus never looks like a hang
      if (host_req_out && wait_cnt >= int'(HOST_TO_CYC)) begin
        timed_out_out <= 1'b1;
        host_req_out  <= 1'b0;
      end
    end
  end
endmodule : pmfh_far_model

// file: sim/pmfh_top_tb_top.sv
// pmfh_top_tb_top: self-checking bench for the telemetry and fault handler.
// assumes shortened refresh and hiccup counts; inputs change on rising edges.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp=%0h got=%0h", nm, e, g); end end
module pmfh_top_tb_top;
  import pmfh_pkg::*;
  localparam int unsigned RC = 20;
  localparam int unsigned HC = 10;
  logic        clk_in, srst_in = 1'b1, en = 1'b0, ibus = 1'b0, cfg = 1'b0, aon = 1'b0;
  logic        pmon = 1'b0, smon = 1'b0, gp = 1'b0, pg = 1'b1, go = 1'b0;
  logic [11:0] av = 12'h000;
  logic [7:0]  ai = 8'h00, at = 8'h19, blen = 8'h02;
  logic [3:0]  rf = 4'h0, af, lf;
  logic [2:0]  igp = 3'h0, osd;
  logic        busy, hreq, tmo, hold, grant, pstb, spoll, pgl, on, gsd;
  pmfh_fctl_t  fc = '0;
  pmfh_telem_t ct, mt, ex;
  pmfh_state_t st, tgt;
  int          fail_count = 0, n_checks = 0, n;
  logic [31:0] seed = 32'h0001_18b3;

  pmfh_top #(.REFRESH_CYCLES(RC), .HICCUP_CYCLES(HC)) pmfh_top_i (
    .clk_in(clk_in), .srst_in(srst_in), .adc_vout_in(av), .adc_iout_in(ai),
    .adc_temp_in(at), .real_fault_in(rf), .fault_ctl_in(fc), .enable_pin_in(en),
    .ibus_power_in(ibus), .configured_in(cfg), .auto_on_in(aon), .p_monitor_in(pmon),
    .s_monitor_in(smon), .group_prop_in(gp), .inter_group_prop_in(igp),
    .power_good_in(pg), .sync_comm_busy_in(busy), .host_req_in(hreq),
    .host_hold_out(hold), .host_grant_out(grant), .conv_telem_out(ct),
    .mgr_telem_out(mt), .poll_strobe_out(pstb), .status_poll_out(spoll),
    .pg_low_out(pgl), .output_on_out(on), .active_fault_out(af),
    .latched_fault_out(lf), .group_shutdown_out(gsd),
    .other_group_shutdown_out(osd), .state_out(st));
  pmfh_far_model pmfh_far_model_i (
    .clk_in(clk_in), .srst_in(srst_in), .go_in(go), .busy_len_in(blen),
    .grant_in(grant), .sync_comm_busy_out(busy), .host_req_out(hreq),
    .timed_out_out(tmo));

  // free-running 50 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // current model; temperature kept at or above reference, so no rounding doubt
  function automatic int comp(input int i, input int t);
    return i - (i * (t - int'(TEMP_REF))) / 256;
  endfunction : comp
  function automatic logic hit(input int k);
    case (k)
      0: return pstb;
      1: return grant;
      default: return logic'(st === tgt);
    endcase
  endfunction : hit
  task automatic tk(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask : tk
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_hi(input int k, input int lim);
    int c;
    c = 0;
    while (hit(k) !== 1'b1 && c < lim) begin
      tk(1);
      c++;
    end
    if (hit(k) !== 1'b1) begin
      fail_count++;
      $display("[FAIL] wait %0d exp=1 got=0", k);
      tally_and_finish();
    end
  endtask : wait_hi
  task automatic wait_st(input pmfh_state_t s, input int lim);
    tgt = s;
    wait_hi(2, lim);
  endtask : wait_st
  // one-cycle pulse on a fault control field: 0 set, 1 clear, 2 off, 3 on
  task automatic pulse(input int k, input logic [3:0] m);
    @(posedge clk_in);
    case (k)
      0: fc.inject_set <= m;
      1: fc.inject_clr <= m;
      2: fc.cmd_off <= 1'b1;
      default: fc.cmd_on <= 1'b1;
    endcase
    @(posedge clk_in);
    fc.inject_set <= 4'h0;
    fc.inject_clr <= 4'h0;
    fc.cmd_off <= 1'b0;
    fc.cmd_on <= 1'b0;
  endtask : pulse

  // main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    en <= 1'b1;
    aon <= 1'b1;
    cfg <= 1'b1;
    pmon <= 1'b1;
    smon <= 1'b1;
    tk(8);
    `CHK("off without bus power", PMFH_OFF, st)
    @(posedge clk_in);
    ibus <= 1'b1;
    wait_st(PMFH_RUN, 8);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      seed = xs(seed);
      av <= seed[11:0];
      ai <= seed[19:12];
      at <= (i == 0) ? 8'h19 : 8'h19 + {1'b0, seed[30:24]};
      tk(6);
      `CHK("vout", av, ct.vout_reading)
      `CHK("iout", 8'(comp(ai, at)), ct.iout_reading)
      `CHK("temp", at, ct.temp_reading)
    end
    wait_hi(0, 2 * RC);
    ex = '{av, 8'(comp(ai, at)), at};
    `CHK("mgr copy", ex, mt)
    `CHK("status poll", 1'b1, spoll)
    n = 0;
    do begin
      tk(1);
      n++;
    end while (pstb !== 1'b1 && n < 100);
    `CHK("refresh gap", RC, n)
    @(posedge clk_in);
    pmon <= 1'b0;
    smon <= 1'b0;
    av <= ~av;
    n = 0;
    repeat (2 * RC + 4) begin
      tk(1);
      if (spoll === 1'b1) n++;
    end
    `CHK("status polls off", 0, n)
    `CHK("mgr held", ex, mt)
    `CHK("vout live", av, ct.vout_reading)
    @(posedge clk_in);
    pg <= 1'b0;
    tk(4);
    `CHK("pg low seen", 1'b1, pgl)
    @(posedge clk_in);
    pg <= 1'b1;
    tk(4);
    `CHK("pg low gone", 1'b0, pgl)
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_in);
      blen <= j ? 8'h0c : 8'h02;
      go <= 1'b1;
      @(posedge clk_in);
      go <= 1'b0;
      tk(3);
      if (j == 1) `CHK("host hold", 1'b1, hold)
      wait_hi(1, 24);
      `CHK("busy at grant", 1'b0, busy)
      `CHK("host timeout", 1'b0, tmo)
      tk(4);
      `CHK("grant released", 1'b0, grant)
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      gp <= i[0];
      igp <= 3'(i + 1);
      pulse(0, 4'(1 << i));
      tk(5);
      `CHK("fault state", PMFH_FAULT, st)
      `CHK("output off", 1'b0, on)
      `CHK("trigger held", 4'(1 << i), af)
      `CHK("group down", i[0], gsd)
      `CHK("other groups", 3'(i[0] ? i + 1 : 0), osd)
      pulse(1, 4'(1 << i));
      wait_st(PMFH_HICCUP, 4);
      n = 0;
      while (st === PMFH_HICCUP && n < 100) begin
        tk(1);
        n++;
      end
      `CHK("hiccup length", HC, n)
      `CHK("restart", PMFH_RUN, st)
      `CHK("output on", 1'b1, on)
      `CHK("group follows", 4'h0, {gsd, osd})
    end
    @(posedge clk_in);
    fc.latching <= 4'ha;
    aon <= 1'b0;
    pulse(0, 4'h2);
    pulse(1, 4'h2);
    tk(HC + 4);
    `CHK("latched stays off", PMFH_FAULT, st)
    `CHK("latch kept", 4'h2, lf)
    pulse(3, 4'h0);
    tk(3);
    `CHK("lone on refused", PMFH_FAULT, st)
    pulse(2, 4'h0);
    tk(3);
    `CHK("off holds", PMFH_OFF, st)
    pulse(3, 4'h0);
    wait_st(PMFH_RUN, 6);
    `CHK("latch cleared", 4'h0, lf)
    pulse(0, 4'h8);
    pulse(1, 4'h8);
    @(posedge clk_in);
    en <= 1'b0;
    aon <= 1'b1;
    tk(6);
    @(posedge clk_in);
    en <= 1'b1;
    wait_st(PMFH_RUN, 12);
    `CHK("toggle clears", 4'h0, lf)
    @(posedge clk_in);
    fc.latching <= 4'h0;
    rf <= 4'h4;
    wait_st(PMFH_FAULT, 8);
    @(posedge clk_in);
    rf <= 4'h0;
    wait_st(PMFH_HICCUP, 8);
    wait_st(PMFH_RUN, HC + 4);
    tally_and_finish();
  end
endmodule : pmfh_top_tb_top
